// >>> dv/cqi_sw_mem_model.sv
// Partner model: command consumer and event memory with random response delays
module cqi_sw_mem_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Handshakes
  input wire logic cmd_valid,
  input wire logic evt_wr_req,
  output logic     cmd_take,
  output logic     evt_wr_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int cmd_wait = 0;
  int evt_wait = 0;

  // ==========================================================================
  // Take only offered entries; done only once the write is really pending
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_take <= 1'b0;
      evt_wr_done <= 1'b0;
    end else begin
      cmd_take <= 1'b0;
      evt_wr_done <= 1'b0;
      if (cmd_valid && !cmd_take) begin
        if (cmd_wait == 0) cmd_take <= 1'b1;
        cmd_wait = (cmd_wait == 0) ? $urandom_range(0, 3) : cmd_wait - 1;
      end
      if (evt_wr_req && !evt_wr_done) begin
        if (evt_wait == 0) evt_wr_done <= 1'b1;
        evt_wait = (evt_wait == 0) ? $urandom_range(0, 4) : evt_wait - 1;
      end
    end
  end
endmodule

// >>> dv/cqi_top_properties.sv
// Checker: port-level timing properties of the circular queue index logic
module cqi_top_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  // Command side
  input wire logic        cmd_valid,
  input wire logic [18:0] cmd_slot,
  input wire logic        cmd_take,
  // Event side
  input wire logic        evt_valid,
  input wire logic        evt_stall,
  input wire logic        evt_accept,
  input wire logic        evt_dropped,
  input wire logic        evt_wr_req,
  input wire logic [18:0] evt_wr_slot,
  input wire logic        evt_wr_done,
  input wire logic        evt_published
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================================
  // Last slot written; wrap to zero is allowed since the size is not seen here
  logic [18:0] last_slot_reg;
  logic [18:0] last_slot_next;
  always_comb last_slot_next = (evt_wr_req && evt_wr_done) ? evt_wr_slot : last_slot_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_slot_reg <= 19'h0_0000;
    else last_slot_reg <= last_slot_next;
  end

  // ==========================================================================
  // Assertions
  a_take_drops_valid: assert property (cmd_valid && cmd_take |=> !cmd_valid)
    else $error("cmd_valid stayed high after a take");
  a_cmd_slot_step: assert property (cmd_valid && cmd_take ##2 cmd_valid |->
    (cmd_slot == $past(cmd_slot, 2) + 19'h0_0001) || (cmd_slot == 19'h0_0000))
    else $error("command slot did not advance by one");
  a_evt_slot_next: assert property ($rose(evt_wr_req) |->
    (evt_wr_slot == last_slot_reg + 19'h0_0001) || (evt_wr_slot == 19'h0_0000))
    else $error("event slot not next after previous");
  a_accept_needs_valid: assert property (evt_accept && !evt_dropped |->
    evt_valid ##1 evt_wr_req)
    else $error("committed event not written");
  a_drop_only_nonstall: assert property (evt_dropped |-> evt_accept && !evt_stall)
    else $error("stalled event dropped");
  a_req_holds_slot: assert property (evt_wr_req && !evt_wr_done |=>
    evt_wr_req && $stable(evt_wr_slot))
    else $error("entry write released early");
  a_done_then_publish: assert property (evt_wr_req && evt_wr_done |=>
    !evt_wr_req ##1 evt_published)
    else $error("publish pulse missing after entry write");
  a_publish_after_done: assert property ($rose(evt_published) |->
    $past(evt_wr_done, 2))
    else $error("index published before entry data visible");
  a_apb_one_wait: assert property (psel && penable && !$past(penable) |->
    !pready ##1 pready)
    else $error("register access not one wait state");

  // Main scenarios reached
  c_drop: cover property (evt_dropped);
  c_take: cover property (cmd_valid && cmd_take);
  c_pub:  cover property (evt_published);
endmodule

bind cqi_top cqi_top_chk u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .cmd_valid(cmd_valid), .cmd_slot(cmd_slot), .cmd_take(cmd_take),
  .evt_valid(evt_valid), .evt_stall(evt_stall), .evt_accept(evt_accept),
  .evt_dropped(evt_dropped), .evt_wr_req(evt_wr_req), .evt_wr_slot(evt_wr_slot),
  .evt_wr_done(evt_wr_done), .evt_published(evt_published));

// >>> dv/tb_top.sv
// Testbench: APB-driven checks of command and event queue index handling
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  logic        pready, pslverr, cmd_valid, cmd_take, evt_valid = 0, evt_stall = 0;
  logic        evt_accept, evt_dropped, evt_wr_req, evt_wr_done, evt_published;
  logic [18:0] cmd_slot, evt_wr_slot;
  int          miscompares = 0, samples_checked = 0, cp = 0, cc = 0, ep = 0, k;

  // ==========================================================================
  // Clock, design and partner
  always #2 pclk = ~pclk;
  cqi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_slot(cmd_slot), .cmd_take(cmd_take),
    .evt_valid(evt_valid), .evt_stall(evt_stall), .evt_accept(evt_accept),
    .evt_dropped(evt_dropped), .evt_wr_req(evt_wr_req), .evt_wr_slot(evt_wr_slot),
    .evt_wr_done(evt_wr_done), .evt_published(evt_published));
  cqi_sw_mem_model u_sw (.pclk(pclk), .presetn(presetn), .cmd_valid(cmd_valid),
    .evt_wr_req(evt_wr_req), .cmd_take(cmd_take), .evt_wr_done(evt_wr_done));

  // ==========================================================================
  // Compare, verdict and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // One idle edge first so two transfers never assign psel in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle budget here: a slave that never answers is left to the watchdog
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  // Hold the event until taken; a held stall event must wait past minw cycles
  task automatic send_evt(input logic stall, input logic drop, input int minw);
    int n;
    @(posedge pclk);
    evt_valid <= 1'b1;
    evt_stall <= stall;
    n = 0;
    do begin @(posedge pclk); n++; end while (evt_accept !== 1'b1 && n < 300);
    chk({31'h0, evt_accept}, 32'h0000_0001);
    chk({31'h0, evt_dropped}, {31'h0, drop});
    chk({31'h0, n > minw}, 32'h0000_0001);
    evt_valid <= 1'b0;
  endtask

  // Reference indexes for 4-entry queues: slot is bits 1:0, wrap bit 2
  always @(posedge pclk) begin
    if (cmd_valid === 1'b1 && cmd_take === 1'b1) begin
      chk({13'h0, cmd_slot}, cc & 3);
      cc = (cc + 1) & 7;
    end
    if (evt_wr_req === 1'b1 && evt_wr_done === 1'b1) begin
      chk({13'h0, evt_wr_slot}, ep & 3);
      ep = (ep + 1) & 7;
    end
  end

  // Watchdog: the tests need a few hundred cycles
  initial begin
    #80000;
    miscompares++;
    close_out;
  end

  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(1));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(cqi_pkg::OFF_CMD_PRD, 32'h0000_0000);
    rd_chk(cqi_pkg::OFF_STATUS, 32'h0000_0005);
    rd_chk(cqi_pkg::OFF_SEC_ID, 32'h0000_0000);
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk({31'h0, rerr}, 32'h0000_0001);
    // Producer below consumer with equal wraps: device must stand still
    apb(1'b1, cqi_pkg::OFF_QSIZE, 32'h0000_0202);
    apb(1'b1, cqi_pkg::OFF_CMD_CNS, 32'h0000_0002);
    apb(1'b1, cqi_pkg::OFF_CMD_PRD, 32'h0000_0001);
    apb(1'b1, cqi_pkg::OFF_CTRL, 32'h0000_0003);
    rd_chk(cqi_pkg::OFF_STATUS, 32'h0000_0014);
    repeat (20) begin @(posedge pclk); chk({31'h0, cmd_valid}, 32'h0000_0000); end
    cp = 2;
    cc = 2;
    apb(1'b1, cqi_pkg::OFF_CMD_PRD, 32'h0000_0002);
    // Random bursts up to a full queue, junk in the ignored upper bits
    repeat (6) begin
      cp = (cp + $urandom_range(1, 4)) & 7;
      apb(1'b1, cqi_pkg::OFF_CMD_PRD, 32'h000F_FFF8 | cp);
      k = 0;
      do begin apb(1'b0, cqi_pkg::OFF_STATUS, 32'h0000_0000); k++; end
        while (r[0] !== 1'b1 && k < 40);
      chk({31'h0, r[0]}, 32'h0000_0001);
      rd_chk(cqi_pkg::OFF_CMD_CNS, cp);
    end
    // Fill the event queue, then overflow with a plain and a stalled event
    repeat (4) send_evt(1'($urandom_range(0, 1)), 1'b0, 0);
    send_evt(1'b0, 1'b1, 0);
    rd_chk(cqi_pkg::OFF_STATUS, 32'h0000_0009);
    rd_chk(cqi_pkg::OFF_DROPS, 32'h0000_0001);
    fork
      send_evt(1'b1, 1'b0, 10);
      begin repeat (12) @(posedge pclk); apb(1'b1, cqi_pkg::OFF_EVT_CNS, 32'h0000_0001); end
    join
    k = 0;
    while (evt_published !== 1'b1 && k < 50) begin @(posedge pclk); k++; end
    chk({31'h0, evt_published}, 32'h0000_0001);
    rd_chk(cqi_pkg::OFF_EVT_PRD, ep);
    close_out;
  end
endmodule

// >>> src/cqi_pkg.sv
// Package: register map, field layout, reset values and types for the circular queue index logic
package cqi_pkg;

  // ==========================================================================
  // Index geometry
  localparam int unsigned IDX_REG_W    = 20;          // Producer/consumer register width
  localparam int unsigned MAX_LOG2     = 19;          // Largest index width in bits
  localparam int unsigned LOG2_W       = 5;           // Width of a size field
  localparam logic [4:0]  LOG2_MAX_VAL = 5'h13;       // 19 as a size code
  localparam logic [4:0]  LOG2_RST     = 5'h00;       // One-entry queues after reset

  // ==========================================================================
  // Register byte offsets on the APB
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_QSIZE   = 8'h04;
  localparam logic [7:0] OFF_CMD_PRD = 8'h08;
  localparam logic [7:0] OFF_CMD_CNS = 8'h0C;
  localparam logic [7:0] OFF_EVT_PRD = 8'h10;
  localparam logic [7:0] OFF_EVT_CNS = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;
  localparam logic [7:0] OFF_DROPS   = 8'h1C;
  localparam logic [7:0] OFF_SEC_ID  = 8'h20;

  // ==========================================================================
  // Field positions
  localparam int unsigned CTRL_CMD_EN_BIT  = 0;
  localparam int unsigned CTRL_EVT_EN_BIT  = 1;
  localparam int unsigned QSIZE_CMD_LSB    = 0;
  localparam int unsigned QSIZE_EVT_LSB    = 8;
  localparam int unsigned SEC_PRESENT_BIT  = 0;

  // Secure queues are not built in this instance, so the capability reads zero
  localparam logic SECURE_STATE_PRESENT = 1'b0;

  // ==========================================================================
  // Reset values
  localparam logic [19:0] IDX_RST   = 20'h0_0000;
  localparam logic [15:0] DROPS_RST = 16'h0000;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic empty;
    logic full;
    logic consistent;
  } cqi_qstat_t;

  typedef struct packed {
    logic        valid;
    logic [18:0] slot;
  } cqi_slot_t;

  typedef enum logic [1:0] {
    CQI_EVT_IDLE,
    CQI_EVT_WRITE,
    CQI_EVT_PUBLISH
  } cqi_evt_state_t;

endpackage

// >>> src/cqi_qstat.sv
// Module: full/empty/consistency decode of one queue's producer and consumer indexes
module cqi_qstat (
  // Indexes as stored
  input  wire logic [19:0]       producer_index,
  input  wire logic [19:0]       consumer_index,
  // Configured index width
  input  wire logic [4:0]        log2_size,
  // Decoded state
  output cqi_pkg::cqi_qstat_t    stat
);

  logic [19:0] slot_mask;
  logic        producer_index_wrap;
  logic        consumer_index_wrap;
  logic [19:0] producer_index_slot;
  logic [19:0] consumer_index_slot;

  // ==========================================================================
  // Mask off bits above the wrap flag before any comparison
  always_comb begin
    slot_mask = (20'h0_0001 << log2_size) - 20'h0_0001;
    producer_index_slot = producer_index & slot_mask;
    consumer_index_slot = consumer_index & slot_mask;
    producer_index_wrap = producer_index[log2_size];
    consumer_index_wrap = consumer_index[log2_size];
    stat.empty = (producer_index_slot == consumer_index_slot) && (producer_index_wrap == consumer_index_wrap);
    stat.full  = (producer_index_slot == consumer_index_slot) && (producer_index_wrap != consumer_index_wrap);
    // Producer ahead with differing wraps, or behind with equal wraps, is illegal
    stat.consistent = !(((producer_index_slot > consumer_index_slot) && (producer_index_wrap != consumer_index_wrap)) ||
                        ((producer_index_slot < consumer_index_slot) && (producer_index_wrap == consumer_index_wrap)));
  end

endmodule

// >>> src/cqi_top.sv
// Module: APB-programmed command/event queue index logic
//
// Contract
// - Queues hold 2^n entries, n from 0 to 19; index registers are 20 bits.
// - Wrap flag sits just above the index field; higher bits are ignored.
// - Equal indexes and equal wraps mean empty; nothing is consumed.
// - Equal indexes and differing wraps mean full; nothing is produced.
// - The index owner toggles the wrap flag when passing the top entry.
// - Indexes only increment or wrap to zero, never move backwards.
// - Command queue: software advances producer, device advances consumer.
// - Event queue: device advances producer, software advances consumer.
// - With inconsistent indexes the device stops producing or consuming.
// - While not empty, the consumer keeps consuming until indexes match.
// - Commands are consumed strictly in order, one queue per security state.
// - Output entries are appended sequentially, slot after slot.
// - Producer index moves only after entry data is visible in memory.
// - Producer index is visible no later than the queue notification.
// - Stalled-transaction events wait while the event queue is full.
// - Other events are discarded while the event queue cannot take them.
// - One non-secure event queue; a secure one only if capability reads 1.
// - Events are written only when the queue is enabled, error-free, not full.
//
// Design decisions made here: the register offsets and register access over APB.
module cqi_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Command consumer side
  output logic             cmd_valid,
  output logic      [18:0] cmd_slot,
  input  wire logic        cmd_take,
  // Event source side
  input  wire logic        evt_valid,
  input  wire logic        evt_stall,
  output logic             evt_accept,
  output logic             evt_dropped,
  // Event memory write side
  output logic             evt_wr_req,
  output logic      [18:0] evt_wr_slot,
  input  wire logic        evt_wr_done,
  output logic             evt_published
);

  // ==========================================================================
  // State
  logic                    cmd_en_reg,   cmd_en_next;
  logic                    evt_en_reg,   evt_en_next;
  logic [4:0]              cmd_log2_reg, cmd_log2_next;
  logic [4:0]              evt_log2_reg, evt_log2_next;
  logic [19:0]             cmd_producer_index_reg, cmd_producer_index_next;
  logic [19:0]             cmd_consumer_index_reg, cmd_consumer_index_next;
  logic [19:0]             evt_producer_index_reg, evt_producer_index_next;
  logic [19:0]             evt_consumer_index_reg, evt_consumer_index_next;
  logic [15:0]             drops_reg,    drops_next;
  logic                    ack_reg,      ack_next;
  logic [31:0]             rdata_reg,    rdata_next;
  logic                    err_reg,      err_next;
  cqi_pkg::cqi_evt_state_t evt_st_reg,   evt_st_next;
  cqi_pkg::cqi_slot_t      cmd_out_reg,  cmd_out_next;
  cqi_pkg::cqi_slot_t      evt_out_reg,  evt_out_next;
  logic                    pub_reg,      pub_next;

  cqi_pkg::cqi_qstat_t     cmd_stat;
  cqi_pkg::cqi_qstat_t     evt_stat;
  logic                    wr_fire;
  logic                    mapped;
  logic                    evt_writable;
  logic                    evt_commit;
  logic                    evt_discard;

  // ==========================================================================
  // Advance an index by one as an (n+1)-bit counter: the carry out of the
  // slot field lands in the wrap flag, and bits above it are cleared
  function automatic logic [19:0] idx_incr(input logic [19:0] idx, input logic [4:0] n);
    logic [19:0] keep;
    keep     = (20'h0_0002 << n) - 20'h0_0001;
    idx_incr = (idx + 20'h0_0001) & keep;
  endfunction

  // Clamp a size code to the largest index width
  function automatic logic [4:0] clamp_log2(input logic [4:0] v);
    clamp_log2 = (v > cqi_pkg::LOG2_MAX_VAL) ? cqi_pkg::LOG2_MAX_VAL : v;
  endfunction

  // Slot field of an index, zero-extended above the configured width
  function automatic logic [18:0] slot_of(input logic [19:0] idx, input logic [4:0] n);
    logic [19:0] m;
    m       = (20'h0_0001 << n) - 20'h0_0001;
    slot_of = idx[18:0] & m[18:0];
  endfunction

  // ==========================================================================
  // Status decode for both queues
  cqi_qstat u_cmd_stat (
    .producer_index      (cmd_producer_index_reg),
    .consumer_index      (cmd_consumer_index_reg),
    .log2_size (cmd_log2_reg),
    .stat      (cmd_stat)
  );

  cqi_qstat u_evt_stat (
    .producer_index      (evt_producer_index_reg),
    .consumer_index      (evt_consumer_index_reg),
    .log2_size (evt_log2_reg),
    .stat      (evt_stat)
  );

  // ==========================================================================
  // APB handshake: one wait state so read data comes from a flop
  assign wr_fire = psel && penable && ack_reg && pwrite;
  assign pready  = psel && penable && ack_reg;
  assign prdata  = rdata_reg;
  assign pslverr = pready && err_reg;

  always_comb begin
    case (paddr[7:0])
      cqi_pkg::OFF_CTRL, cqi_pkg::OFF_QSIZE, cqi_pkg::OFF_CMD_PRD, cqi_pkg::OFF_CMD_CNS,
      cqi_pkg::OFF_EVT_PRD, cqi_pkg::OFF_EVT_CNS, cqi_pkg::OFF_STATUS, cqi_pkg::OFF_DROPS,
      cqi_pkg::OFF_SEC_ID: mapped = (paddr[31:8] == 24'h00_0000);
      default:             mapped = 1'b0;
    endcase
  end

  // Read mux and ack, captured in the first access cycle
  always_comb begin
    ack_next   = psel && penable && !ack_reg;
    rdata_next = rdata_reg;
    err_next   = err_reg;
    if (psel && penable && !ack_reg) begin
      err_next   = !mapped;
      rdata_next = 32'h0000_0000;
      case (paddr[7:0])
        cqi_pkg::OFF_CTRL: begin
          rdata_next[cqi_pkg::CTRL_CMD_EN_BIT] = cmd_en_reg;
          rdata_next[cqi_pkg::CTRL_EVT_EN_BIT] = evt_en_reg;
        end
        cqi_pkg::OFF_QSIZE: begin
          rdata_next[cqi_pkg::QSIZE_CMD_LSB +: 5] = cmd_log2_reg;
          rdata_next[cqi_pkg::QSIZE_EVT_LSB +: 5] = evt_log2_reg;
        end
        cqi_pkg::OFF_CMD_PRD: rdata_next[19:0] = cmd_producer_index_reg;
        cqi_pkg::OFF_CMD_CNS: rdata_next[19:0] = cmd_consumer_index_reg;
        cqi_pkg::OFF_EVT_PRD: rdata_next[19:0] = evt_producer_index_reg;
        cqi_pkg::OFF_EVT_CNS: rdata_next[19:0] = evt_consumer_index_reg;
        cqi_pkg::OFF_STATUS: rdata_next[5:0] = {!evt_stat.consistent, !cmd_stat.consistent,
                                                evt_stat.full, evt_stat.empty,
                                                cmd_stat.full, cmd_stat.empty};
        cqi_pkg::OFF_DROPS:  rdata_next[15:0] = drops_reg;
        cqi_pkg::OFF_SEC_ID:
          rdata_next[cqi_pkg::SEC_PRESENT_BIT] = cqi_pkg::SECURE_STATE_PRESENT;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Configuration registers; sizes may change only while the queue is off
  always_comb begin
    cmd_en_next   = cmd_en_reg;
    evt_en_next   = evt_en_reg;
    cmd_log2_next = cmd_log2_reg;
    evt_log2_next = evt_log2_reg;
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_CTRL) begin
      cmd_en_next = pwdata[cqi_pkg::CTRL_CMD_EN_BIT];
      evt_en_next = pwdata[cqi_pkg::CTRL_EVT_EN_BIT];
    end
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_QSIZE) begin
      if (!cmd_en_reg)
        cmd_log2_next = clamp_log2(pwdata[cqi_pkg::QSIZE_CMD_LSB +: 5]);
      if (!evt_en_reg)
        evt_log2_next = clamp_log2(pwdata[cqi_pkg::QSIZE_EVT_LSB +: 5]);
    end
  end

  // ==========================================================================
  // Command queue: software owns the producer, the device the consumer.
  // The device-owned index is writable only while the queue is disabled, so
  // software can set a consistent starting point without racing the device.
  always_comb begin
    cmd_producer_index_next = cmd_producer_index_reg;
    cmd_consumer_index_next = cmd_consumer_index_reg;
    cmd_out_next  = cmd_out_reg;
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_CMD_PRD)
      cmd_producer_index_next = pwdata[19:0];
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_CMD_CNS && !cmd_en_reg)
      cmd_consumer_index_next = pwdata[19:0];
    else if (cmd_out_reg.valid && cmd_take)
      cmd_consumer_index_next = idx_incr(cmd_consumer_index_reg, cmd_log2_reg);
    // Offer the head entry while not empty and the indexes make sense
    cmd_out_next.valid = cmd_en_reg && !cmd_stat.empty && cmd_stat.consistent &&
                         !(cmd_out_reg.valid && cmd_take);
    cmd_out_next.slot  = slot_of(cmd_consumer_index_reg, cmd_log2_reg);
  end

  assign cmd_valid = cmd_out_reg.valid;
  assign cmd_slot  = cmd_out_reg.slot;

  // ==========================================================================
  // Event queue acceptance: commit only into a writable queue, hold stalls
  assign evt_writable = evt_en_reg && evt_stat.consistent && !evt_stat.full;
  assign evt_commit   = evt_valid && evt_writable && (evt_st_reg == cqi_pkg::CQI_EVT_IDLE);
  assign evt_discard  = evt_valid && !evt_stall && !evt_writable;
  // A stalled event sees no accept until space frees, so its source holds it
  assign evt_accept   = evt_commit || evt_discard;
  assign evt_dropped  = evt_discard;

  // Event producer sequence: write entry, wait for visibility, then publish
  always_comb begin
    evt_st_next   = evt_st_reg;
    evt_producer_index_next = evt_producer_index_reg;
    evt_consumer_index_next = evt_consumer_index_reg;
    evt_out_next  = evt_out_reg;
    pub_next      = 1'b0;
    drops_next    = drops_reg;
    if (evt_discard && drops_reg != 16'hFFFF)
      drops_next = drops_reg + 16'h0001;
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_EVT_CNS)
      evt_consumer_index_next = pwdata[19:0];
    if (wr_fire && paddr[7:0] == cqi_pkg::OFF_EVT_PRD && !evt_en_reg)
      evt_producer_index_next = pwdata[19:0];
    case (evt_st_reg)
      cqi_pkg::CQI_EVT_IDLE: begin
        if (evt_commit) begin
          evt_out_next.valid = 1'b1;
          evt_out_next.slot  = slot_of(evt_producer_index_reg, evt_log2_reg);
          evt_st_next        = cqi_pkg::CQI_EVT_WRITE;
        end
      end
      cqi_pkg::CQI_EVT_WRITE: begin
        // The index stays put until memory reports the entry visible
        if (evt_wr_done) begin
          evt_out_next.valid = 1'b0;
          evt_producer_index_next      = idx_incr(evt_producer_index_reg, evt_log2_reg);
          evt_st_next        = cqi_pkg::CQI_EVT_PUBLISH;
        end
      end
      cqi_pkg::CQI_EVT_PUBLISH: begin
        // Notify in the cycle after the new index is already readable
        pub_next    = 1'b1;
        evt_st_next = cqi_pkg::CQI_EVT_IDLE;
      end
      default: evt_st_next = cqi_pkg::CQI_EVT_IDLE;
    endcase
  end

  assign evt_wr_req    = evt_out_reg.valid;
  assign evt_wr_slot   = evt_out_reg.slot;
  assign evt_published = pub_reg;

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_en_reg   <= 1'b0;
      evt_en_reg   <= 1'b0;
      cmd_log2_reg <= cqi_pkg::LOG2_RST;
      evt_log2_reg <= cqi_pkg::LOG2_RST;
      cmd_producer_index_reg <= cqi_pkg::IDX_RST;
      cmd_consumer_index_reg <= cqi_pkg::IDX_RST;
      evt_producer_index_reg <= cqi_pkg::IDX_RST;
      evt_consumer_index_reg <= cqi_pkg::IDX_RST;
      drops_reg    <= cqi_pkg::DROPS_RST;
      ack_reg      <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      err_reg      <= 1'b0;
      evt_st_reg   <= cqi_pkg::CQI_EVT_IDLE;
      cmd_out_reg  <= '0;
      evt_out_reg  <= '0;
      pub_reg      <= 1'b0;
    end else begin
      cmd_en_reg   <= cmd_en_next;
      evt_en_reg   <= evt_en_next;
      cmd_log2_reg <= cmd_log2_next;
      evt_log2_reg <= evt_log2_next;
      cmd_producer_index_reg <= cmd_producer_index_next;
      cmd_consumer_index_reg <= cmd_consumer_index_next;
      evt_producer_index_reg <= evt_producer_index_next;
      evt_consumer_index_reg <= evt_consumer_index_next;
      drops_reg    <= drops_next;
      ack_reg      <= ack_next;
      rdata_reg    <= rdata_next;
      err_reg      <= err_next;
      evt_st_reg   <= evt_st_next;
      cmd_out_reg  <= cmd_out_next;
      evt_out_reg  <= evt_out_next;
      pub_reg      <= pub_next;
    end
  end

endmodule
